// ---- hw/dlp_host.sv ----
// Host end: AXI4-Lite controller that drives link clock and lanes.
// Assumes one outstanding write and one outstanding read.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dlp_host #(
  parameter int SW          = dlp_pkg::SAMPLE_W,
  parameter int HALF_CYC    = 3,
  parameter int STARTUP_CYC = dlp_pkg::STARTUP_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  dlp_link_if.host         link
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0]    ctrl;
    logic [SW-1:0] samp_a;
    logic [SW-1:0] samp_b;
    logic [7:0]    div;
    logic          lclk;
    logic [SW-1:0] lane_a;
    logic [SW-1:0] lane_b;
    logic [31:0]   boot;
    logic          ready;
    logic          req;
    logic          we;
    logic [7:0]    addr;
    logic [7:0]    wdata;
    logic [7:0]    cfg_rd;
    logic          aw_got;
    logic [7:0]    awaddr;
    logic          w_got;
    logic [31:0]   wd;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
  } dlp_host_st_t;

  dlp_host_st_t st_r;
  dlp_host_st_t st_nxt;

  logic       run;
  logic       aw_do;
  logic       w_do;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;

  always_comb
  begin
    st_nxt = st_r;
    run    = st_r.ctrl[dlp_pkg::HB_RUN];

    // ========================================================
    // Link clock divider and startup wait
    // Divider runs free; a stop waits out the high phase
    st_nxt.div = (st_r.div == 8'(HALF_CYC - 1)) ? 8'h00
                 : st_r.div + 8'h01;
    if (st_r.div == 8'(HALF_CYC - 1) && (run || st_r.lclk))
      st_nxt.lclk = ~st_r.lclk;
    if (!run)
    begin
      st_nxt.boot  = 32'h0;
      st_nxt.ready = 1'b0;
    end
    else if (st_r.boot == 32'(STARTUP_CYC))
      st_nxt.ready = 1'b1;
    else
      st_nxt.boot = st_r.boot + 32'h1;

    // Lanes change mid half-period, away from both link edges
    if (st_r.div != 8'(HALF_CYC / 2))
      st_nxt.lane_a = st_r.lane_a;
    else if (!(st_r.ready && st_r.ctrl[dlp_pkg::HB_STREAM]))
    begin
      st_nxt.lane_a = '0;
      st_nxt.lane_b = '0;
    end
    else
    begin
      if (st_r.ctrl[dlp_pkg::HB_SINGLE])
      begin
        st_nxt.lane_a = '0;
        st_nxt.lane_b = st_r.samp_b;
        if (st_r.ctrl[dlp_pkg::HB_INCR])
          st_nxt.samp_b = st_r.samp_b + SW'(1);
      end
      else
      begin
        st_nxt.lane_a = st_r.samp_a;
        st_nxt.lane_b = st_r.samp_b;
        if (st_r.ctrl[dlp_pkg::HB_INCR])
        begin
          st_nxt.samp_a = st_r.samp_a + SW'(2);
          st_nxt.samp_b = st_r.samp_b + SW'(2);
        end
      end
    end

    // ========================================================
    // Config request to the device
    if (st_r.req && link.cfg_ack)
    begin
      st_nxt.req    = 1'b0;
      st_nxt.cfg_rd = link.cfg_rdata;
    end

    // ========================================================
    // AXI4-Lite write
    aw_do    = s_axi_awvalid & st_r.awready;
    w_do     = s_axi_wvalid & st_r.wready;
    cmd_addr = st_r.wd[7:0];
    cmd_data = st_r.wd[15:8];
    if (aw_do)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_do)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wd    = s_axi_wdata;
    end
    if (st_r.aw_got && st_r.w_got)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      unique case (st_r.awaddr)
        dlp_pkg::H_CTRL:   st_nxt.ctrl   = st_r.wd[3:0];
        dlp_pkg::H_SAMP_A: st_nxt.samp_a = st_r.wd[SW-1:0];
        dlp_pkg::H_SAMP_B: st_nxt.samp_b = st_r.wd[SW-1:0];
        dlp_pkg::H_CMD:
        begin
          if (!st_r.req)
          begin
            st_nxt.req   = 1'b1;
            st_nxt.we    = st_r.wd[dlp_pkg::HB_CMD_WE];
            st_nxt.addr  = cmd_addr;
            st_nxt.wdata = cmd_data;
            // Update enable held off until startup is done
            if (cmd_addr == dlp_pkg::ADDR_PORT_CTL && !st_r.ready)
              st_nxt.wdata[dlp_pkg::BIT_UPD_EN] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid
                     & ~(st_r.aw_got & st_r.w_got);
    st_nxt.wready  = ~st_nxt.w_got & ~st_nxt.bvalid
                     & ~(st_r.aw_got & st_r.w_got);

    // ========================================================
    // AXI4-Lite read
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      unique case (s_axi_araddr)
        dlp_pkg::H_CTRL:   st_nxt.rdata = {28'h0, st_r.ctrl};
        dlp_pkg::H_SAMP_A: st_nxt.rdata = 32'(st_r.samp_a);
        dlp_pkg::H_SAMP_B: st_nxt.rdata = 32'(st_r.samp_b);
        dlp_pkg::H_STAT:
          st_nxt.rdata = {16'h0, st_r.cfg_rd, 6'h00, st_r.ready,
                          st_r.req};
        default:           st_nxt.rdata = 32'h0;
      endcase
    end
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    st_nxt.arready = ~st_nxt.rvalid & ~(s_axi_arvalid & st_r.arready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bresp   = dlp_pkg::AXI_OKAY;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = dlp_pkg::AXI_OKAY;
  assign s_axi_rvalid  = st_r.rvalid;
  assign link.source_sync_clock_in = st_r.lclk;
  assign link.sample_lane_first    = st_r.lane_a;
  assign link.sample_lane_second   = st_r.lane_b;
  assign link.cfg_req   = st_r.req;
  assign link.cfg_we    = st_r.we;
  assign link.cfg_addr  = st_r.addr;
  assign link.cfg_wdata = st_r.wdata;
endmodule : dlp_host
`default_nettype wire

// ---- hw/dlp_pkg.sv ----
// Package: shared constants of the sample-port link.
// Assumes a 200 MHz aclk on both ends.
package dlp_pkg;
  // ==========================================================
  // Widths and timing
  localparam int SAMPLE_W    = 16;
  localparam int CLK_MHZ     = 200;
  localparam int CLK_NS      = 5;
  localparam int DET_MHZ     = 25;
  localparam int LOSS_HALF_NS = 1000 / (2 * DET_MHZ);
  localparam int LOSS_CYC    = LOSS_HALF_NS / CLK_NS;
  localparam int STARTUP_US  = 1000;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int PH_N        = 20;

  // ==========================================================
  // Device register map and fields
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h03;
  localparam logic [7:0] ADDR_PORT_CTL = 8'h04;
  localparam logic [7:0] ADDR_PH_CTL   = 8'h05;
  localparam logic [7:0] ADDR_PH_RD    = 8'h06;
  localparam int BIT_SRC_EN   = 0;
  localparam int BIT_SRC_OK   = 1;
  localparam int BIT_A_EN     = 0;
  localparam int BIT_B_EN     = 1;
  localparam int BIT_SINGLE   = 2;
  localparam int BIT_UPD_EN   = 3;
  localparam int BIT_MANUAL   = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [SAMPLE_W-1:0] MID_SCALE = 16'h0000;
  localparam logic [SAMPLE_W-1:0] LANE_OFF  = 16'h0000;

  // ==========================================================
  // Controller register map (AXI4-Lite byte addresses)
  localparam logic [7:0] H_CTRL   = 8'h00;
  localparam logic [7:0] H_SAMP_A = 8'h04;
  localparam logic [7:0] H_SAMP_B = 8'h08;
  localparam logic [7:0] H_CMD    = 8'h0C;
  localparam logic [7:0] H_STAT   = 8'h10;
  localparam int HB_RUN    = 0;
  localparam int HB_STREAM = 1;
  localparam int HB_SINGLE = 2;
  localparam int HB_INCR   = 3;
  localparam int HB_CMD_WE = 16;
  localparam logic [1:0] AXI_OKAY = 2'h0;

  // ==========================================================
  // Phase comparator codes in drift order
  function automatic logic [7:0] dlp_ph_code(input logic [4:0] idx);
    logic [7:0] c;
    c = 8'h00;
    unique case (idx)
      5'h00: c = 8'h03;  5'h01: c = 8'h04;  5'h02: c = 8'h05;
      5'h03: c = 8'h15;  5'h04: c = 8'h25;  5'h05: c = 8'h35;
      5'h06: c = 8'h45;  5'h07: c = 8'h55;  5'h08: c = 8'h54;
      5'h09: c = 8'h53;  5'h0A: c = 8'h52;  5'h0B: c = 8'h51;
      5'h0C: c = 8'h50;  5'h0D: c = 8'h40;  5'h0E: c = 8'h30;
      5'h0F: c = 8'h20;  5'h10: c = 8'h10;  5'h11: c = 8'h00;
      5'h12: c = 8'h01;  5'h13: c = 8'h02;
      default: c = 8'h00;
    endcase
    return c;
  endfunction : dlp_ph_code

  // Best mux phase per comparator code; unknown codes keep phase
  function automatic logic [1:0] dlp_opt_phase(input logic [7:0] ph,
                                               input logic single,
                                               input logic [1:0] cur);
    logic [1:0] d;
    logic [1:0] s;
    d = cur;
    s = cur;
    unique case (ph)
      8'h03, 8'h04, 8'h05, 8'h15, 8'h25:
      begin d = 2'h2; s = 2'h0; end
      8'h35, 8'h45, 8'h55, 8'h54, 8'h53:
      begin d = 2'h0; s = 2'h2; end
      8'h52, 8'h51, 8'h50, 8'h40, 8'h30:
      begin d = 2'h1; s = 2'h2; end
      8'h20, 8'h10, 8'h00, 8'h01, 8'h02:
      begin d = 2'h3; s = 2'h0; end
      default:
      begin d = cur; s = cur; end
    endcase
    return single ? s : d;
  endfunction : dlp_opt_phase
endpackage : dlp_pkg

// ---- hw/dlp_link_if.sv ----
// Interface: sample lanes, link clock and config port between ends.
// Assumes both ends share aclk for the config port only.
`timescale 1ns/1ps
`default_nettype none
interface dlp_link_if;
  logic                          source_sync_clock_in;
  logic [dlp_pkg::SAMPLE_W-1:0]  sample_lane_first;
  logic [dlp_pkg::SAMPLE_W-1:0]  sample_lane_second;
  logic                          cfg_req;
  logic                          cfg_we;
  logic [7:0]                    cfg_addr;
  logic [7:0]                    cfg_wdata;
  logic [7:0]                    cfg_rdata;
  logic                          cfg_ack;

  modport device (input source_sync_clock_in, input sample_lane_first,
                  input sample_lane_second, input cfg_req, input cfg_we,
                  input cfg_addr, input cfg_wdata, output cfg_rdata,
                  output cfg_ack);
  modport host (output source_sync_clock_in, output sample_lane_first,
                output sample_lane_second, output cfg_req, output cfg_we,
                output cfg_addr, output cfg_wdata, input cfg_rdata,
                input cfg_ack);
endinterface : dlp_link_if
`default_nettype wire

// ---- hw/dlp_sync2.sv ----
// Two-flop synchroniser for a bus of pin levels.
// Assumes bits are sampled together by the reader downstream.
`timescale 1ns/1ps
`default_nettype none
module dlp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dlp_sync_st_t;

  dlp_sync_st_t st_r;
  dlp_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule : dlp_sync2
`default_nettype wire

// ---- hw/dlp_dev.sv ----
// Device end: DDR sample capture, port modes, mute and phase tracking.
// Assumes lanes change away from link clock edges, as the host does.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Lanes carry one word per link clock edge
// - Sample words are two's complement
// - Single mode uses lane second only
// - Dual mode uses both lanes
// - Bit 0 enables lane first, else zero
// - Bit 1 enables lane second, else zero
// - Bit 2 selects single mode
// - Bit 3 clear forces mid-scale code
// - Port control at data_port_control resets 0x00
// - Controller sets single mode, lane second only
// - Controller enables both lanes, interleaves words
// - Lane first word precedes lane second
// - Comparators track drift, steer mux phase
// - Controller waits 1 ms before data
// - Update enable only after startup
// - Register sync_phase_readout shows comparator bits
// - sync_phase_control phase field auto-updated, read-only
// - Manual bit stops automatic phase updates
// - Software tracks phase in manual mode
// - Codes 0x03-sync_phase_control give 10 dual, 00 single
// - Absent link clock mutes, resets datapath
// - 0x03 bit 0 enables clock receiver
module dlp_dev #(
  parameter int SW = dlp_pkg::SAMPLE_W
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  dlp_link_if.device         link,
  output logic [SW-1:0]      dac_code,
  output logic               dac_strobe,
  output logic               clock_present,
  output logic [1:0]         mux_phase
);
  // ==========================================================
  // State
  typedef struct packed {
    logic          lclk_d;
    logic [3:0]    gap;
    logic          present;
    logic [SW-1:0] pend;
    logic          pend_v;
    logic [SW-1:0] code;
    logic          strobe;
    logic          src_en;
    logic [3:0]    port_ctl;
    logic          manual;
    logic [1:0]    phase;
    logic [7:0]    ph;
    logic [4:0]    div;
    logic [7:0]    rdata;
    logic          ack;
  } dlp_dev_st_t;

  dlp_dev_st_t st_r;
  dlp_dev_st_t st_nxt;

  // ==========================================================
  // Pin synchronisers
  logic [2*SW:0] pins_s;
  logic          lclk_s;
  logic [SW-1:0] lane_a_s;
  logic [SW-1:0] lane_b_s;

  dlp_sync2 #(.W(2*SW+1)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({link.source_sync_clock_in, link.sample_lane_first,
               link.sample_lane_second}),
    .q       (pins_s)
  );

  assign lclk_s   = pins_s[2*SW];
  assign lane_a_s = pins_s[2*SW-1:SW];
  assign lane_b_s = pins_s[SW-1:0];

  // ==========================================================
  // Next state
  logic          edge_any;
  logic          edge_rise;
  logic          single;
  logic          upd;
  logic [SW-1:0] word_a;
  logic [SW-1:0] word_b;
  logic [7:0]    ph_new;

  always_comb
  begin
    st_nxt    = st_r;
    edge_any  = (lclk_s != st_r.lclk_d);
    edge_rise = lclk_s & ~st_r.lclk_d;
    single    = st_r.port_ctl[dlp_pkg::BIT_SINGLE];
    upd       = st_r.port_ctl[dlp_pkg::BIT_UPD_EN];
    word_a    = st_r.port_ctl[dlp_pkg::BIT_A_EN] ? lane_a_s
                : dlp_pkg::LANE_OFF;
    word_b    = st_r.port_ctl[dlp_pkg::BIT_B_EN] ? lane_b_s
                : dlp_pkg::LANE_OFF;
    ph_new    = dlp_pkg::dlp_ph_code(st_r.div);
    st_nxt.lclk_d = lclk_s;
    st_nxt.strobe = 1'b0;
    st_nxt.ack    = 1'b0;

    // Sample divider runs free; its phase against the link drifts
    st_nxt.div = (st_r.div == 5'(dlp_pkg::PH_N - 1)) ? 5'h00
                 : st_r.div + 5'h01;

    // Clock detector: receiver off counts as no clock
    if (!st_r.src_en)
      st_nxt.gap = 4'h0;
    else if (edge_any)
      st_nxt.gap = 4'h0;
    else if (st_r.gap != 4'hF)
      st_nxt.gap = st_r.gap + 4'h1;
    st_nxt.present = st_r.src_en && edge_any ? 1'b1
                     : (st_r.gap < 4'(dlp_pkg::LOSS_CYC)) & st_r.present
                       & st_r.src_en;

    if (!st_r.present)
    begin
      // Datapath held in reset while the clock is missing
      st_nxt.pend   = '0;
      st_nxt.pend_v = 1'b0;
      st_nxt.code   = dlp_pkg::MID_SCALE;
    end
    else if (edge_any)
    begin
      st_nxt.strobe = 1'b1;
      if (single)
      begin
        st_nxt.code   = upd ? word_b : dlp_pkg::MID_SCALE;
        st_nxt.pend_v = 1'b0;
      end
      else
      begin
        // Lane first goes out now, lane second on the next cycle
        st_nxt.code   = upd ? word_a : dlp_pkg::MID_SCALE;
        st_nxt.pend   = upd ? word_b : dlp_pkg::MID_SCALE;
        st_nxt.pend_v = 1'b1;
      end
    end
    else if (st_r.pend_v)
    begin
      st_nxt.strobe = 1'b1;
      st_nxt.code   = upd ? st_r.pend : dlp_pkg::MID_SCALE;
      st_nxt.pend_v = 1'b0;
    end

    // Comparators sample divider phase on each rising link edge
    if (st_r.present && edge_rise)
    begin
      st_nxt.ph = ph_new;
      if (!st_r.manual)
        st_nxt.phase = dlp_pkg::dlp_opt_phase(ph_new, single,
                                              st_r.phase);
    end

    // Config port: one access per request, acked next cycle
    if (link.cfg_req && !st_r.ack)
    begin
      st_nxt.ack = 1'b1;
      unique case (link.cfg_addr)
        dlp_pkg::ADDR_CLK_CTRL:
        begin
          if (link.cfg_we)
            st_nxt.src_en = link.cfg_wdata[dlp_pkg::BIT_SRC_EN];
          st_nxt.rdata = {6'h00, st_r.present, st_r.src_en};
        end
        dlp_pkg::ADDR_PORT_CTL:
        begin
          if (link.cfg_we)
            st_nxt.port_ctl = link.cfg_wdata[3:0];
          st_nxt.rdata = {4'h0, st_r.port_ctl};
        end
        dlp_pkg::ADDR_PH_CTL:
        begin
          if (link.cfg_we)
          begin
            st_nxt.manual = link.cfg_wdata[dlp_pkg::BIT_MANUAL];
            // Phase field is read-only while automatic
            if (link.cfg_wdata[dlp_pkg::BIT_MANUAL])
              st_nxt.phase = link.cfg_wdata[1:0];
          end
          st_nxt.rdata = {5'h00, st_r.manual, st_r.phase};
        end
        dlp_pkg::ADDR_PH_RD:
          st_nxt.rdata = st_r.ph;
        default:
          st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r          <= '0;
      st_r.port_ctl <= dlp_pkg::REG_RESET[3:0];
      st_r.code     <= dlp_pkg::MID_SCALE;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs
  assign dac_code       = st_r.code;
  assign dac_strobe     = st_r.strobe;
  assign clock_present  = st_r.present;
  assign mux_phase      = st_r.phase;
  assign link.cfg_rdata = st_r.rdata;
  assign link.cfg_ack   = st_r.ack;
endmodule : dlp_dev
`default_nettype wire

// ---- tb/dlp_link_monitor.sv ----
// Checker of the config port and link wires between the two ends.
// Assumes it sees the interface signals on the shared aclk.
`timescale 1ns/1ps
`default_nettype none
module dlp_link_monitor #(
  parameter int HALF_CYC = 3
) (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic                         source_sync_clock_in,
  input wire logic [dlp_pkg::SAMPLE_W-1:0] sample_lane_first,
  input wire logic [dlp_pkg::SAMPLE_W-1:0] sample_lane_second,
  input wire logic                         cfg_req,
  input wire logic                         cfg_we,
  input wire logic [7:0]                   cfg_addr,
  input wire logic [7:0]                   cfg_wdata,
  input wire logic [7:0]                   cfg_rdata,
  input wire logic                         cfg_ack
);
  // ==========================================================
  // Helper state: last control writes, cycles since clock edge
  logic [3:0] port_r;
  logic [1:0] ph_r;
  logic       man_r;
  logic       ck_r;
  logic [7:0] hc_r;
  logic       wr;
  assign wr = cfg_req && !cfg_ack && cfg_we;
  always_ff @(posedge aclk)
  begin
    ck_r <= source_sync_clock_in;
    hc_r <= (source_sync_clock_in != ck_r) ? 8'h00 :
            (hc_r == 8'hFF) ? hc_r : hc_r + 8'h01;
    if (!aresetn)
    begin
      port_r <= 4'h0;
      ph_r   <= 2'h0;
      man_r  <= 1'b0;
      hc_r   <= 8'hFF;
    end
    else if (wr && cfg_addr == 8'h04)
      port_r <= cfg_wdata[3:0];
    else if (wr && cfg_addr == 8'h05)
    begin
      man_r <= cfg_wdata[2];
      ph_r  <= cfg_wdata[2] ? cfg_wdata[1:0] : ph_r;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_taken;
    cfg_req && !cfg_ack;
  endsequence
  sequence s_read(logic [7:0] a);
    cfg_req && !cfg_ack && !cfg_we && cfg_addr == a;
  endsequence
  property p_ack_next; s_taken |=> cfg_ack; endproperty
  property p_ack_pulse; cfg_ack |=> !cfg_ack; endproperty
  property p_ack_cause; cfg_ack |-> $past(cfg_req); endproperty
  property p_req_drop; cfg_ack |=> !cfg_req; endproperty
  property p_hold;
    s_taken |=> $stable(cfg_addr) && $stable(cfg_we) && $stable(cfg_wdata);
  endproperty
  property p_port_rd; s_read(8'h04) |=> cfg_rdata == {4'h0, port_r};
  endproperty
  property p_phase_rd;
    s_read(8'h05) |=> cfg_rdata[2] == man_r &&
                      (!man_r || cfg_rdata[1:0] == ph_r);
  endproperty
  property p_lane_hold;
    $changed(source_sync_clock_in) |-> $stable(sample_lane_second);
  endproperty
  property p_clk_half;
    $changed(source_sync_clock_in) |-> hc_r >= HALF_CYC - 1;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("config ack missing");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("config ack too long");
  a_ack_cause: assert property (p_ack_cause)
    else $error("config ack without request");
  a_req_drop: assert property (p_req_drop)
    else $error("config request kept after ack");
  a_hold: assert property (p_hold)
    else $error("config request changed while waiting");
  a_port_rd: assert property (p_port_rd)
    else $error("port control readback wrong");
  a_phase_rd: assert property (p_phase_rd)
    else $error("phase control readback wrong");
  a_lane_hold: assert property (p_lane_hold)
    else $error("lane changed on link clock edge");
  a_clk_half: assert property (p_clk_half)
    else $error("link clock half period short");
endmodule : dlp_link_monitor
`default_nettype wire

// ---- tb/test_dlp_link.sv ----
// Bench: host and device joined by the link interface.
// Assumes startup shortened to 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_dlp_link;
  localparam int HC = 3;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, dac_strobe;
  logic        clock_present;
  logic [7:0]  awaddr, araddr, rd, ctl;
  logic [31:0] wdata, rdata, seed, st;
  logic [1:0]  bresp, rresp, mux_phase;
  logic [15:0] dac_code, a, b, ea, eb, c;
  int          mismatches, compares, cyc;
  logic [7:0]  modes [5] = '{8'h0B, 8'h0A, 8'h0E, 8'h03, 8'h09};
  dlp_link_if link_bus ();
  dlp_host #(.HALF_CYC(HC), .STARTUP_CYC(50)) i_dlp_host (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_bus));
  dlp_dev i_dlp_dev (.aclk(aclk), .aresetn(aresetn), .link(link_bus),
    .dac_code(dac_code), .dac_strobe(dac_strobe),
    .clock_present(clock_present), .mux_phase(mux_phase));
  dlp_link_monitor #(.HALF_CYC(HC)) i_dlp_link_monitor (.aclk(aclk),
    .aresetn(aresetn), .source_sync_clock_in(link_bus.source_sync_clock_in),
    .sample_lane_first(link_bus.sample_lane_first),
    .sample_lane_second(link_bus.sample_lane_second),
    .cfg_req(link_bus.cfg_req), .cfg_we(link_bus.cfg_we),
    .cfg_addr(link_bus.cfg_addr), .cfg_wdata(link_bus.cfg_wdata),
    .cfg_rdata(link_bus.cfg_rdata), .cfg_ack(link_bus.cfg_ack));
  // ==========================================================
  // Clock, timeout and helpers
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Dual-port best phase per comparator code
  function automatic logic [1:0] opt(input logic [7:0] k);
    case (k)
      8'h03, 8'h04, 8'h05, 8'h15, 8'h25: return 2'h2;
      8'h35, 8'h45, 8'h55, 8'h54, 8'h53: return 2'h0;
      8'h52, 8'h51, 8'h50, 8'h40, 8'h30: return 2'h1;
      default: return 2'h3;
    endcase
  endfunction : opt
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      aw_t = aw_t | awready;
      w_t = w_t | wready;
      awvalid <= !aw_t;
      wvalid <= !w_t;
    end
    while (!(aw_t && w_t && bvalid));
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] ad, output logic [31:0] d);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  task automatic cfg(input logic [7:0] ad, d, input logic we,
                     output logic [7:0] r);
    axw(dlp_pkg::H_CMD, {15'h0000, we, d, ad});
    do axr(dlp_pkg::H_STAT, st);
    while (st[0] !== 1'b0);
    r = st[15:8];
  endtask : cfg
  task automatic grab(output logic [15:0] k);
    do @(posedge aclk);
    while (dac_strobe !== 1'b1);
    k = dac_code;
  endtask : grab
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // ==========================================================
  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    seed = 32'h0000BD14;
    {mismatches, compares} = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cfg(dlp_pkg::ADDR_PORT_CTL, 8'h00, 1'b0, rd);
    chk("port_reset", rd, 8'h00);
    axw(dlp_pkg::H_CTRL, 32'h3);
    cfg(dlp_pkg::ADDR_CLK_CTRL, 8'h01, 1'b1, rd);
    do axr(dlp_pkg::H_STAT, st);
    while (st[1] !== 1'b1);
    cfg(dlp_pkg::ADDR_CLK_CTRL, 8'h00, 1'b0, rd);
    chk("present", {rd[1], clock_present}, 2'h3);
    foreach (modes[i])
    begin
      ctl = modes[i];
      a = 16'(rnd() >> 17) | 16'h0001;
      b = ~a;
      eb = (ctl[1] && ctl[3]) ? b : 16'h0000;
      ea = ctl[2] ? eb : (ctl[0] && ctl[3]) ? a : 16'h0000;
      c = ~ea;
      axw(dlp_pkg::H_SAMP_A, {16'h0000, a});
      axw(dlp_pkg::H_SAMP_B, {16'h0000, b});
      axw(dlp_pkg::H_CTRL, {29'h0, ctl[2], 2'h3});
      cfg(dlp_pkg::ADDR_PORT_CTL, ctl, 1'b1, rd);
      repeat (30) @(posedge aclk);
      for (int k = 0; k < 8 && c !== ea; k++)
        grab(c);
      chk("word_first", c, ea);
      grab(c);
      chk("word_second", c, eb);
    end
    cfg(dlp_pkg::ADDR_PH_CTL, 8'h05, 1'b1, rd);
    repeat (40) @(posedge aclk);
    cfg(dlp_pkg::ADDR_PH_CTL, 8'h00, 1'b0, rd);
    chk("manual", {rd, 6'h00, mux_phase}, 16'h0501);
    cfg(dlp_pkg::ADDR_PH_CTL, 8'h00, 1'b1, rd);
    repeat (40) @(posedge aclk);
    axw(dlp_pkg::H_CTRL, 32'h0);
    repeat (20) @(posedge aclk);
    cfg(dlp_pkg::ADDR_PH_RD, 8'h00, 1'b0, ctl);
    cfg(dlp_pkg::ADDR_PH_CTL, 8'h00, 1'b0, rd);
    chk("auto", {rd, mux_phase}, {6'h00, opt(ctl), opt(ctl)});
    chk("absent", {clock_present, dac_code}, 17'h0);
    close_out();
  end
endmodule : test_dlp_link
`default_nettype wire
